// ===== core/huc_defs.svh
// Constants of the HID serial configuration and data handler
`ifndef HUC_DEFS_SVH
`define HUC_DEFS_SVH
// Command and record layout
`define HUC_CMD_SET 8'h01
`define HUC_REC_LAST 3'h7
`define HUC_WLEN8 8'h08
`define HUC_STOP_MAX 8'h01
`define HUC_PAR_MAX 8'h02
// Supported line rates
`define HUC_RATE_9600 32'h0000_2580
`define HUC_RATE_19200 32'h0000_4b00
`define HUC_RATE_38400 32'h0000_9600
`define HUC_RATE_57600 32'h0000_e100
`define HUC_RATE_115200 32'h0001_c200
// Reset values
`define HUC_RST_RATE `HUC_RATE_9600
`define HUC_RST_STOP2 1'b0
`define HUC_RST_PARITY 2'h0
`define HUC_RST_IN_EN 1'b1
// Data report layout
`define HUC_RPT_LAST 5'h1f
`define HUC_MAX_LEN 8'h1f
// Register offsets
`define HUC_REG_RATE 4'h0
`define HUC_REG_FMT 4'h4
`define HUC_REG_STATUS 4'h8
`define HUC_REG_CTRL 4'hc
`endif

// ===== core/huc_pkg.sv
// Types of the HID serial configuration and data handler
package huc_pkg;
  typedef enum logic [2:0] {
    HUC_IDLE = 3'b001,
    HUC_GET = 3'b010,
    HUC_IN = 3'b100
  } huc_state_e;
  typedef struct packed {
    huc_state_e st;
    logic [31:0] rate;
    logic stop2;
    logic [1:0] parity;
    logic [63:0] shadow;
    logic [2:0] get_idx;
    logic get_valid;
    logic [7:0] get_byte;
    logic get_last;
    logic [4:0] in_idx;
    logic [4:0] in_len;
    logic in_valid;
    logic [7:0] in_byte;
    logic in_last;
    logic [4:0] out_idx;
    logic [4:0] out_len;
    logic cfg_apply;
    logic bad_cfg;
    logic in_en;
    logic [31:0] rdata;
  } huc_state_s;
endpackage : huc_pkg

// ===== core/huc_top.sv
// HID serial bridge: configuration record, data reports, buffers
// Behaviour
// R01 - Configuration only via feature get and set
// R02 - Get returns eight bytes, command first
// R03 - Bytes 1-4 little-endian rate, five rates only
// R04 - Byte 5: 0 one stop, 1 two
// R05 - Byte 6: none, odd, even parity
// R06 - Byte 7 word length always eight
// R07 - Set with command 01 applies record
// R08 - Output reports feed transmit buffer
// R09 - Input reports drain receive buffer
// R10 - Byte 0 of report is length
// R11 - Length 0 to 31, longer splits; the code does not split, it clamps a longer output length byte to 31
// R12 - Reset format eight bits, no parity, one stop
// R13 - Reset line rate 9600
// R14 - Bad set record ignored, config kept
// R15 - Bytes beyond length are discarded
`timescale 1ns/100ps
`default_nettype none
`include "huc_defs.svh"

// -----------------------------------------------
// Small FIFO with registered full and empty flags
// -----------------------------------------------
module huc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic core_clk, // Clock
  input wire logic rst, // Async reset
  input wire logic in_valid, // Write request
  input wire logic [WIDTH-1:0] in_data, // Write data
  output logic in_ready, // Room left
  output logic out_valid, // Data present
  output logic [WIDTH-1:0] out_data, // Head word
  input wire logic out_ready, // Pop request
  output logic [$clog2(DEPTH+1)-1:0] level // Words held
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic full;
    logic empty;
  } huc_fifo_s;
  huc_fifo_s s;
  huc_fifo_s n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = in_valid & ~s.full;
  assign pop = out_ready & ~s.empty;
  assign in_ready = ~s.full;
  assign out_valid = ~s.empty;
  assign out_data = mem[s.rp];
  assign level = s.cnt;

  // Pointers wrap naturally, so depth must stay a power of two
  always_comb begin
    n = s;
    if (push) begin
      n.wp = AW'(s.wp + 1'b1);
    end
    if (pop) begin
      n.rp = AW'(s.rp + 1'b1);
    end
    n.cnt = CW'(s.cnt + CW'(push) - CW'(pop));
    n.full = (n.cnt == CW'(DEPTH));
    n.empty = (n.cnt == '0);
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '{wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
    end else begin
      s <= n;
    end
  end

  // Storage needs no reset, only written words are read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[s.wp] <= in_data;
    end
  end
endmodule : huc_fifo

// -----------------------------------------------
// Top: feature record, report streams, registers
// -----------------------------------------------
module huc_top
  import huc_pkg::*;
(
  input wire logic core_clk, // 20 MHz clock
  input wire logic rst, // Async reset, high
  input wire logic fset_stb, // Set record byte strobe
  input wire logic [2:0] fset_idx, // Set record byte index
  input wire logic [7:0] fset_byte, // Set record byte
  input wire logic get_req, // Get record request
  output logic get_valid, // Get record byte valid
  output logic [7:0] get_byte, // Get record byte
  output logic get_last, // Last record byte
  input wire logic out_stb, // Output report byte
  input wire logic [7:0] out_byte, // Output report data
  output logic out_ready, // Output byte taken
  input wire logic in_req, // Input report request
  output logic in_valid, // Input report byte valid
  output logic [7:0] in_byte, // Input report byte
  output logic in_last, // Last report byte
  output logic tx_valid, // Byte for transmitter
  output logic [7:0] tx_data, // Transmit byte
  input wire logic tx_ready, // Transmitter takes byte
  input wire logic rx_valid, // Received byte
  input wire logic [7:0] rx_data, // Received data
  output logic rx_ready, // Receive buffer room
  output logic [31:0] cfg_rate, // Line rate
  output logic cfg_stop2, // Two stop bits
  output logic [1:0] cfg_parity, // 0 none 1 odd 2 even
  output logic cfg_apply, // New settings pulse
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata // Read data
);
  huc_state_s s;
  huc_state_s n;
  logic tx_push;
  logic tx_in_ready;
  logic [2:0] tx_level;
  logic rx_pop;
  logic rx_out_valid;
  logic [7:0] rx_out_data;
  logic [2:0] rx_level;
  logic [63:0] rec;

  // -----------------------------------------------
  // Helpers
  // -----------------------------------------------
  function automatic logic rate_ok(input logic [31:0] r);
    return (r == `HUC_RATE_9600) || (r == `HUC_RATE_19200) ||
           (r == `HUC_RATE_38400) || (r == `HUC_RATE_57600) ||
           (r == `HUC_RATE_115200);
  endfunction : rate_ok

  function automatic logic cfg_ok(input logic [63:0] r);
    return (r[7:0] == `HUC_CMD_SET) && rate_ok(r[39:8]) &&
           (r[47:40] <= `HUC_STOP_MAX) && (r[55:48] <= `HUC_PAR_MAX) &&
           (r[63:56] == `HUC_WLEN8);
  endfunction : cfg_ok

  // Record byte as the host reads it
  function automatic logic [7:0] rec_byte(input logic [2:0] i,
      input logic [31:0] r, input logic st2, input logic [1:0] par);
    logic [63:0] v;
    v = {`HUC_WLEN8, 6'h00, par, 7'h00, st2, r, `HUC_CMD_SET};
    return v[{i, 3'h0} +: 8];
  endfunction : rec_byte

  // -----------------------------------------------
  // Buffers
  // -----------------------------------------------
  huc_fifo #(.WIDTH(8), .DEPTH(4)) u_tx_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(tx_push),
    .in_data(out_byte),
    .in_ready(tx_in_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready),
    .level(tx_level)
  );

  huc_fifo #(.WIDTH(8), .DEPTH(4)) u_rx_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(rx_out_valid),
    .out_data(rx_out_data),
    .out_ready(rx_pop),
    .level(rx_level)
  );

  // Whole output report stalls while the transmit buffer is full
  assign out_ready = tx_in_ready;

  // -----------------------------------------------
  // Next state
  // -----------------------------------------------
  always_comb begin
    n = s;
    rec = {fset_byte, s.shadow[55:0]};
    tx_push = 1'b0;
    rx_pop = 1'b0;
    n.cfg_apply = 1'b0;
    n.get_valid = 1'b0;
    n.get_last = 1'b0;
    n.in_valid = 1'b0;
    n.in_last = 1'b0;
    n.rdata = '0;
    // Register reads answer one cycle later, zero when unmapped
    if (reg_rd) begin
      case (reg_addr)
        `HUC_REG_RATE: n.rdata = s.rate;
        `HUC_REG_FMT: n.rdata = {16'h0000, `HUC_WLEN8, 5'h00, s.parity, s.stop2};
        `HUC_REG_STATUS: n.rdata = {29'h0, rx_out_valid, tx_valid, s.bad_cfg};
        `HUC_REG_CTRL: n.rdata = {31'h0, s.in_en};
        default: n.rdata = '0;
      endcase
    end
    // Writes come before the event below, so a new error wins over a clear
    if (reg_wr && reg_addr == `HUC_REG_CTRL) begin
      n.in_en = reg_wdata[0];
    end
    if (reg_wr && reg_addr == `HUC_REG_STATUS && reg_wdata[0]) begin
      n.bad_cfg = 1'b0;
    end
    // Set record collects bytes, judged when byte 7 lands
    if (fset_stb) begin // R01
      n.shadow[{fset_idx, 3'h0} +: 8] = fset_byte;
      if (fset_idx == `HUC_REC_LAST) begin
        if (cfg_ok(rec)) begin // R07 R03 R04 R05 R06
          n.rate = rec[39:8];
          n.stop2 = rec[40];
          n.parity = rec[49:48];
          n.cfg_apply = 1'b1;
        end else begin
          n.bad_cfg = 1'b1; // R14
        end
      end
    end
    // Output report: length byte then payload, excess dropped
    if (out_stb && tx_in_ready) begin
      n.out_idx = 5'(s.out_idx + 5'h01);
      if (s.out_idx == 5'h00) begin // R10
        n.out_len = (out_byte > `HUC_MAX_LEN) ? 5'h1f : out_byte[4:0]; // R11
      end else if (s.out_idx <= s.out_len) begin
        tx_push = 1'b1; // R08 R15
      end
    end
    // Request sequencer; get has priority, busy requests are dropped
    case (s.st)
      HUC_IDLE: begin
        if (get_req) begin // R01
          n.st = HUC_GET;
          n.get_idx = 3'h0;
        end else if (in_req) begin
          n.st = HUC_IN;
          n.in_idx = 5'h00;
          n.in_len = s.in_en ? {2'b00, rx_level} : 5'h00; // R11
        end
      end
      HUC_GET: begin
        n.get_valid = 1'b1;
        n.get_byte = rec_byte(s.get_idx, s.rate, s.stop2, s.parity); // R02
        n.get_last = (s.get_idx == `HUC_REC_LAST);
        n.get_idx = 3'(s.get_idx + 3'h1);
        if (s.get_idx == `HUC_REC_LAST) begin
          n.st = HUC_IDLE;
        end
      end
      HUC_IN: begin
        n.in_valid = 1'b1;
        n.in_last = (s.in_idx == `HUC_RPT_LAST);
        if (s.in_idx == 5'h00) begin
          n.in_byte = {3'h0, s.in_len}; // R10
        end else if (s.in_idx <= s.in_len) begin
          n.in_byte = rx_out_data; // R09
          rx_pop = 1'b1;
        end else begin
          n.in_byte = 8'h00;
        end
        n.in_idx = 5'(s.in_idx + 5'h01);
        if (s.in_idx == `HUC_RPT_LAST) begin
          n.st = HUC_IDLE;
        end
      end
      default: n.st = HUC_IDLE;
    endcase
  end

  // -----------------------------------------------
  // State register
  // -----------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.st <= HUC_IDLE;
      s.rate <= `HUC_RST_RATE; // R13
      s.stop2 <= `HUC_RST_STOP2; // R12
      s.parity <= `HUC_RST_PARITY; // R12
      s.in_en <= `HUC_RST_IN_EN;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign get_valid = s.get_valid;
  assign get_byte = s.get_byte;
  assign get_last = s.get_last;
  assign in_valid = s.in_valid;
  assign in_byte = s.in_byte;
  assign in_last = s.in_last;
  assign cfg_rate = s.rate;
  assign cfg_stop2 = s.stop2;
  assign cfg_parity = s.parity;
  assign cfg_apply = s.cfg_apply;
  assign reg_rdata = s.rdata;

  // -----------------------------------------------
  // Checks
  // -----------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  get_stream_a: assert property ( // R02
    (s.st == HUC_IDLE && get_req) |-> ##2 get_valid ##7 (get_valid && get_last))
    else $error("get record not eight bytes");
  get_cmd_a: assert property ( // R02
    (get_valid && !$past(get_valid)) |-> get_byte == `HUC_CMD_SET)
    else $error("get record byte 0 not command");
  set_apply_a: assert property ( // R07
    (fset_stb && fset_idx == `HUC_REC_LAST && cfg_ok(rec))
      |=> cfg_apply && cfg_rate == $past(rec[39:8]))
    else $error("valid set record not applied");
  bad_keep_a: assert property ( // R14
    (fset_stb && fset_idx == `HUC_REC_LAST && !cfg_ok(rec))
      |=> $stable(cfg_rate) && $stable(cfg_parity) && $stable(cfg_stop2) && s.bad_cfg)
    else $error("bad set record changed config");
  stop_map_a: assert property ( // R04
    (s.st == HUC_GET && s.get_idx == 3'h5) |=> get_byte == {7'h00, $past(cfg_stop2)})
    else $error("stop byte wrong");
  parity_rng_a: assert property ( // R05
    cfg_parity != 2'h3 && rate_ok(cfg_rate)) // R03
    else $error("parity or rate out of range");
  wlen_byte_a: assert property ( // R06
    (s.st == HUC_GET && s.get_idx == 3'h7) |=> get_byte == `HUC_WLEN8 && get_last)
    else $error("word length byte wrong");
  in_len_a: assert property ( // R11
    (in_valid && !$past(in_valid)) |-> in_byte <= `HUC_MAX_LEN && in_byte[4:0] == s.in_len)
    else $error("input report length wrong");
  in_pop_a: assert property ( // R09
    (s.st == HUC_IN && s.in_idx != 5'h00 && s.in_idx <= s.in_len) |-> rx_out_valid)
    else $error("input report ran out of data");
  drop_extra_a: assert property ( // R15
    (out_stb && out_ready && s.out_idx != 5'h00 && s.out_idx > s.out_len)
      |=> tx_level == 3'($past(tx_level) - 3'($past(tx_valid && tx_ready))))
    else $error("excess payload entered buffer");
  reset_cfg_a: assert property ( // R13
    $fell(rst) |-> cfg_rate == `HUC_RATE_9600 && !cfg_stop2 && cfg_parity == 2'h0) // R12
    else $error("reset config wrong");

  get_seen_c: cover property (get_valid && get_last);
  set_ok_c: cover property (cfg_apply);
  set_bad_c: cover property (fset_stb && fset_idx == `HUC_REC_LAST && !cfg_ok(rec));
  in_data_c: cover property (in_valid && !$past(in_valid) && in_byte != 8'h00);
endmodule : huc_top
`default_nettype wire

// ===== dv/huc_host_model.sv
// Host side model: feature records and data reports
`timescale 1ns/100ps
`default_nettype none
module huc_host_model (
  input wire logic core_clk, // Clock
  output var logic fset_stb, // Set byte strobe
  output var logic [2:0] fset_idx, // Set byte index
  output var logic [7:0] fset_byte, // Set byte
  output var logic get_req, // Get request
  input wire logic get_valid, // Get byte valid
  input wire logic [7:0] get_byte, // Get byte
  output var logic out_stb, // Output byte offered
  output var logic [7:0] out_byte, // Output byte
  input wire logic out_ready, // Output byte taken
  output var logic in_req, // Input request
  input wire logic in_valid, // Input byte valid
  input wire logic [7:0] in_byte, // Input byte
  input wire logic in_last // Last input byte
);
  initial begin
    {fset_stb, fset_idx, fset_byte, get_req, out_stb, out_byte, in_req} = '0;
  end
  // Whole record, command byte first; released data line shows the inverse
  task set_rec(input logic [63:0] rec);
    @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      fset_stb <= 1'b1;
      fset_idx <= 3'(i);
      fset_byte <= rec[8*i+:8];
      @(posedge core_clk);
    end
    fset_stb <= 1'b0;
    fset_byte <= ~rec[63:56];
  endtask : set_rec
  task get_rec(output logic [63:0] rec, output int n);
    @(posedge core_clk);
    get_req <= 1'b1;
    @(posedge core_clk);
    get_req <= 1'b0;
    n = 0;
    rec = '0;
    repeat (12) begin
      @(posedge core_clk);
      if (get_valid === 1'b1) begin
        rec[8*n+:8] = get_byte;
        n++;
      end
    end
  endtask : get_rec
  // Always 32 bytes, length first; a long length is sent as is to probe clamping
  task out_rpt(input logic [7:0] len);
    @(posedge core_clk);
    for (int k = 0; k < 32; k++) begin
      out_stb <= 1'b1;
      out_byte <= (k == 0) ? len : 8'h40 + 8'(k);
      do @(posedge core_clk); while (out_ready !== 1'b1);
    end
    out_stb <= 1'b0;
    out_byte <= 8'ha0;
  endtask : out_rpt
  task in_rpt(output logic [255:0] d, output int n, output int last_n);
    @(posedge core_clk);
    in_req <= 1'b1;
    @(posedge core_clk);
    in_req <= 1'b0;
    n = 0;
    last_n = -1;
    repeat (40) begin
      @(posedge core_clk);
      if (in_valid === 1'b1) begin
        d[8*n+:8] = in_byte;
        if (in_last === 1'b1) last_n = n;
        n++;
      end
    end
  endtask : in_rpt
endmodule : huc_host_model
`default_nettype wire

// ===== dv/tb_hid_uart_config_and_data_handler.sv
// Testbench of the HID serial configuration and data handler
`timescale 1ns/100ps
`default_nettype none
module tb_hid_uart_config_and_data_handler;
  logic core_clk, rst, fset_stb, get_req, get_valid, get_last, out_stb, out_ready, in_req, in_valid, in_last;
  logic [2:0] fset_idx;
  logic [7:0] fset_byte, get_byte, out_byte, in_byte, tx_data, rx_data;
  logic tx_valid, tx_ready, rx_valid, rx_ready, cfg_stop2, cfg_apply, reg_wr, reg_rd;
  logic [1:0] cfg_parity;
  logic [31:0] cfg_rate, reg_wdata, reg_rdata;
  logic [3:0] reg_addr;
  logic [7:0] txq[$];
  int failures = 0;
  int num_checks = 0;
  huc_top uut (.core_clk, .rst, .fset_stb, .fset_idx, .fset_byte, .get_req, .get_valid, .get_byte, .get_last,
    .out_stb, .out_byte, .out_ready, .in_req, .in_valid, .in_byte, .in_last, .tx_valid, .tx_data, .tx_ready,
    .rx_valid, .rx_data, .rx_ready, .cfg_rate, .cfg_stop2, .cfg_parity, .cfg_apply, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);
  huc_host_model host (.core_clk, .fset_stb, .fset_idx, .fset_byte, .get_req, .get_valid, .get_byte,
    .out_stb, .out_byte, .out_ready, .in_req, .in_valid, .in_byte, .in_last);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Transmit side sink; samples pre-edge values so pops are seen once
  always @(posedge core_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_data);
  end
  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write
  task reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask : reg_read
  task rx_send(input logic [7:0] b);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    do @(posedge core_clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : rx_send
  task end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    logic [63:0] r;
    int n;
    chk("rate", 64'h2580, 64'(cfg_rate));
    chk("format", 64'h0, 64'({cfg_stop2, cfg_parity}));
    host.get_rec(r, n);
    chk("get count", 64'd8, 64'(n));
    chk("get rec", 64'h0800_0000_0025_8001, r);
    $display("test reset done");
  endtask : t_reset
  // Every rate, both stop counts and all three parities, read back
  task t_rates;
    logic [31:0] rates[5] = '{32'h2580, 32'h4b00, 32'h9600, 32'he100, 32'h1c200};
    logic [63:0] rec, r;
    int n;
    for (int i = 0; i < 5; i++) begin
      rec = {8'h08, 8'(i % 3), 8'(i % 2), rates[i], 8'h01};
      host.set_rec(rec);
      #1;
      chk("apply", 64'h1, 64'(cfg_apply));
      chk("rate", 64'(rates[i]), 64'(cfg_rate));
      chk("stop2", 64'(i % 2), 64'(cfg_stop2));
      chk("parity", 64'(i % 3), 64'(cfg_parity));
      host.get_rec(r, n);
      chk("get rec", rec, r);
    end
    $display("test rates done");
  endtask : t_rates
  // Bad records leave 115200, one stop, odd parity in place
  task t_bad;
    int k[5] = '{0, 1, 5, 6, 7};
    logic [7:0] v[5] = '{8'h02, 8'h01, 8'h02, 8'h03, 8'h07};
    logic [63:0] rec;
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      rec = {8'h08, 8'h01, 8'h00, 32'h1c200, 8'h01};
      rec[8*k[i]+:8] = v[i];
      host.set_rec(rec);
      #1;
      chk("apply", 64'h0, 64'(cfg_apply));
      chk("cfg", {29'h0, 32'h1c200, 3'b001}, {29'h0, cfg_rate, cfg_stop2, cfg_parity});
    end
    reg_read(4'h8, d);
    chk("status err", 64'h1, 64'(d));
    reg_write(4'h8, 32'h1);
    reg_read(4'h8, d);
    chk("status clr", 64'h0, 64'(d));
    reg_write(4'h0, 32'h2580);
    reg_read(4'h0, d);
    chk("rate reg", 64'h1c200, 64'(d));
    reg_read(4'h4, d);
    chk("fmt reg", 64'h0802, 64'(d));
    reg_read(4'h2, d);
    chk("unmapped", 64'h0, 64'(d));
    $display("test bad done");
  endtask : t_bad
  // Stalled transmitter fills the buffer, then short, padded and long reports
  task t_out;
    fork
      host.out_rpt(8'h06);
    join_none
    repeat (14) @(posedge core_clk);
    #1;
    chk("out stall", 64'h0, 64'(out_ready));
    chk("tx valid", 64'h1, 64'(tx_valid));
    @(posedge core_clk);
    tx_ready <= 1'b1;
    wait fork;
    host.out_rpt(8'h02);
    host.out_rpt(8'h28);
    repeat (8) @(posedge core_clk);
    chk("tx count", 64'd39, 64'(txq.size()));
    for (int j = 0; j < 39; j++) begin
      chk("tx byte", 64'(8'h41 + 8'(j < 6 ? j : j < 8 ? j - 6 : j - 8)), 64'(txq[j]));
    end
    $display("test out done");
  endtask : t_out
  // Full receive buffer refuses, report carries its bytes, then empty and disabled
  task t_in;
    logic [255:0] d;
    int n, ln;
    for (int j = 0; j < 4; j++) rx_send(8'h90 + 8'(j));
    @(posedge core_clk);
    rx_valid <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("rx full", 64'h0, 64'(rx_ready));
    rx_valid <= 1'b0;
    host.in_rpt(d, n, ln);
    chk("in count", 64'd32, 64'(n));
    chk("in last", 64'd31, 64'(ln));
    chk("in head", 64'h93_9291_9004, 64'(d[39:0]));
    chk("in pad", 64'h0, 64'(|d[255:40]));
    host.in_rpt(d, n, ln);
    chk("in empty", 64'h0, 64'(d[7:0]));
    reg_write(4'hc, 32'h0);
    rx_send(8'h55);
    host.in_rpt(d, n, ln);
    chk("in off", 64'h0, 64'(d[7:0]));
    reg_write(4'hc, 32'h1);
    host.in_rpt(d, n, ln);
    chk("in on", 64'h55_01, 64'(d[15:0]));
    $display("test in done");
  endtask : t_in
  initial begin
    rst = 1'b1;
    {tx_ready, rx_valid, rx_data, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_rates();
    t_bad();
    t_out();
    t_in();
    end_of_test();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    end_of_test();
  end
endmodule : tb_hid_uart_config_and_data_handler
`default_nettype wire
